// ### rtl/vaor_regs.sv
// Offset, filter and PLL register bank of a three-channel video front end.
// Assumes AXI4-Lite software access, sync and clamp pins from off chip.
//
// How it works
// - With black level compensation on, offset acts digitally, one count per count.
// - With compensation off, offset byte drives upper eight DAC bits.
// - Code 0x80 is mid-scale or zero; 0x00 minimum, 0xFF maximum.
// - Span bit picks half or quarter full-scale analog offset range.
// - Two low DAC bits per channel in config register, red lowest.
// - Bandwidth field bits 3:1 sets front-end corner; resets to 111b.
// - Peaking field bits 7:4 resets to 2; software keeps it at most 2.
// - Line total is fourteen bits, high six bits plus low byte.
// - PLL line total loads only when the low byte is written.
// - Six-bit sample phase, each step one sixty-fourth of pixel.
// - PLL coasts for pre-coast lines before vertical sync starts.
// - PLL keeps coasting for post-coast lines after vertical sync ends.
// - With external clamp, new DAC values apply at clamp leading edge.
// - Without external clamp, DAC values apply at most 100ms after write.
// - Compensation target 0x00 for RGB; 0x80 for colour-difference channels.
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "vaor_params.svh"
module vaor_regs #(
	parameter int unsigned CLAMP_WAIT_CYC = `VAOR_CLAMP_WAIT_MS * `VAOR_CLK_KHZ,
	parameter int WAIT_W = 23,
	parameter int LINE_W = 12
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [`VAOR_AXI_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`VAOR_AXI_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic extClampIn,
	input wire logic intClampPulse,
	input wire logic hsyncIn,
	input wire logic vsyncIn,
	output logic autoBlackLevelComp,
	output logic [2:0][9:0] dacCode,
	output logic dacSpan,
	output logic [2:0][7:0] digOffset,
	output logic [2:0][7:0] blcTarget,
	output logic [2:0] frontEndCorner,
	output logic [3:0] peakingSel,
	output logic [13:0] pllLineTotal,
	output logic [5:0] samplePhase,
	output logic pllCoast
);
	import vaor_pkg::*;

	localparam logic [WAIT_W-1:0] WAIT_LAST = WAIT_W'(CLAMP_WAIT_CYC - 1);

	logic regWrEn;
	vaor_idx_t regWrIdx;
	vaor_byte_t regWrData;
	vaor_idx_t regRdIdx;
	vaor_byte_t regRdData;
	vaor_byte_t chanOffset [3];
	vaor_byte_t appliedOffset [3];
	vaor_byte_t dacCfg;
	vaor_byte_t appliedCfg;
	logic [5:0] totalHigh;
	vaor_byte_t totalLow;
	vaor_byte_t preLines;
	vaor_byte_t postLines;
	vaor_byte_t postCnt;
	logic componentIn;
	logic extClampSel;
	logic pending;
	logic [WAIT_W-1:0] waitCnt;
	logic dacWrite;
	logic applyNow;
	logic [2:0] clampSync;
	logic [2:0] hsSync;
	logic [2:0] vsSync;
	logic clampRise;
	logic hsRise;
	logic vsRise;
	logic vsFall;
	logic [LINE_W-1:0] lineCnt;
	logic [LINE_W-1:0] frameLines;
	logic preHit;
	vaor_coast_t coastState;
	vaor_coast_t next_coastState;

	// One-cycle write strobe for a given index
	function automatic logic wrTo(input vaor_idx_t idx);
		return regWrEn && regWrIdx == idx;
	endfunction : wrTo

	// ==========================================
	// Bus slave
	vaor_axil_slave u_bus (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.regWrEn(regWrEn),
		.regWrIdx(regWrIdx),
		.regWrData(regWrData),
		.regRdIdx(regRdIdx),
		.regRdData(regRdData)
	);

	// ==========================================
	// Software registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dacCfg <= `VAOR_RST_DAC_CFG;
		end else if (wrTo(`VAOR_IDX_DAC_CFG)) begin
			dacCfg <= regWrData; // Reserved bit kept as written
		end
	end

	// Corner and peaking fields, bit 0 dropped
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			frontEndCorner <= `VAOR_RST_CORNER;
			peakingSel <= `VAOR_RST_PEAK;
		end else if (wrTo(`VAOR_IDX_FILTER)) begin
			frontEndCorner <= regWrData[`VAOR_CORNER_LSB +: 3];
			peakingSel <= regWrData[`VAOR_PEAK_LSB +: 4];
		end
	end

	// Line total halves, PLL copy on low byte only
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			totalHigh <= `VAOR_RST_TOT_HI;
			totalLow <= `VAOR_RST_TOT_LO;
			pllLineTotal <= `VAOR_RST_LINE_TOTAL;
		end else if (wrTo(`VAOR_IDX_TOT_HI)) begin
			totalHigh <= regWrData[5:0];
		end else if (wrTo(`VAOR_IDX_TOT_LO)) begin
			totalLow <= regWrData;
			pllLineTotal <= {totalHigh, regWrData};
		end
	end

	// Phase, coast counts and control bits
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			samplePhase <= `VAOR_RST_PHASE;
			preLines <= `VAOR_RST_COAST;
			postLines <= `VAOR_RST_COAST;
			autoBlackLevelComp <= 1'b0;
			componentIn <= 1'b0;
			extClampSel <= 1'b0;
		end else begin
			if (wrTo(`VAOR_IDX_PHASE)) begin
				samplePhase <= regWrData[5:0]; // 5.625 degree steps
			end
			if (wrTo(`VAOR_IDX_PRE)) begin
				preLines <= regWrData;
			end
			if (wrTo(`VAOR_IDX_POST)) begin
				postLines <= regWrData;
			end
			if (wrTo(`VAOR_IDX_CTRL)) begin
				autoBlackLevelComp <= regWrData[`VAOR_AUTO_BLACK_LEVEL_COMP_BIT];
				componentIn <= regWrData[`VAOR_COMP_BIT];
				extClampSel <= regWrData[`VAOR_EXTCLAMP_BIT];
			end
		end
	end

	// Read-back multiplexer
	always_comb begin
		unique case (regRdIdx)
			`VAOR_IDX_RED_OFF: regRdData = chanOffset[0];
			`VAOR_IDX_GRN_OFF: regRdData = chanOffset[1];
			`VAOR_IDX_BLU_OFF: regRdData = chanOffset[2];
			`VAOR_IDX_DAC_CFG: regRdData = dacCfg;
			`VAOR_IDX_FILTER: regRdData = {peakingSel, frontEndCorner, 1'b0};
			`VAOR_IDX_TOT_HI: regRdData = {2'b00, totalHigh};
			`VAOR_IDX_TOT_LO: regRdData = totalLow;
			`VAOR_IDX_PHASE: regRdData = {2'b00, samplePhase};
			`VAOR_IDX_PRE: regRdData = preLines;
			`VAOR_IDX_POST: regRdData = postLines;
			`VAOR_IDX_CTRL: regRdData = {5'h00, extClampSel, componentIn, autoBlackLevelComp};
			`VAOR_IDX_STAT: regRdData = {6'h00, pllCoast, pending};
			default: regRdData = 8'h00;
		endcase
	end

	// ==========================================
	// Pin synchronisers and edge detect
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			clampSync <= 3'h0;
			hsSync <= 3'h0;
			vsSync <= 3'h0;
		end else begin
			clampSync <= {clampSync[1:0], extClampIn};
			hsSync <= {hsSync[1:0], hsyncIn};
			vsSync <= {vsSync[1:0], vsyncIn};
		end
	end

	assign clampRise = clampSync[1] && !clampSync[2];
	assign hsRise = hsSync[1] && !hsSync[2];
	assign vsRise = vsSync[1] && !vsSync[2];
	assign vsFall = !vsSync[1] && vsSync[2];

	// ==========================================
	// Deferred DAC update
	assign dacWrite = wrTo(`VAOR_IDX_RED_OFF) || wrTo(`VAOR_IDX_GRN_OFF) ||
		wrTo(`VAOR_IDX_BLU_OFF) || wrTo(`VAOR_IDX_DAC_CFG);
	assign applyNow = extClampSel ? clampRise :
		(intClampPulse || (pending && waitCnt == WAIT_LAST));

	// Pending flag, a new write beats the apply
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pending <= 1'b0;
		end else if (dacWrite) begin
			pending <= 1'b1;
		end else if (applyNow) begin
			pending <= 1'b0;
		end
	end

	// Fallback wait while no clamp comes
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			waitCnt <= '0;
		end else if (!pending || applyNow || extClampSel) begin
			waitCnt <= '0;
		end else begin
			waitCnt <= waitCnt + 1'b1;
		end
	end

	// Span and low bits taken at the apply
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			appliedCfg <= `VAOR_RST_DAC_CFG;
			dacSpan <= 1'b0;
		end else begin
			if (applyNow) begin
				appliedCfg <= dacCfg;
			end
			dacSpan <= appliedCfg[`VAOR_SPAN_BIT];
		end
	end

	// Per-channel offset, DAC code, digital offset and target
	for (genvar ch = 0; ch < 3; ch++) begin : g_chan
		always_ff @(posedge core_clk or negedge rst_n) begin
			if (!rst_n) begin
				chanOffset[ch] <= `VAOR_RST_OFF;
				appliedOffset[ch] <= `VAOR_RST_OFF;
			end else begin
				if (wrTo(`VAOR_IDX_RED_OFF + 6'(ch))) begin
					chanOffset[ch] <= regWrData;
				end
				if (applyNow) begin
					appliedOffset[ch] <= chanOffset[ch];
				end
			end
		end

		always_ff @(posedge core_clk or negedge rst_n) begin
			if (!rst_n) begin
				dacCode[ch] <= `VAOR_DAC_MID;
				digOffset[ch] <= 8'h00;
				blcTarget[ch] <= `VAOR_BLACK_CODE;
			end else begin
				dacCode[ch] <= autoBlackLevelComp ? `VAOR_DAC_MID :
					{appliedOffset[ch], appliedCfg[`VAOR_DACLOW_BASE + 2 * ch +: 2]};
				digOffset[ch] <= autoBlackLevelComp ?
					(chanOffset[ch] ^ `VAOR_MID_CODE) : 8'h00;
				blcTarget[ch] <= (componentIn && ch != 1) ?
					`VAOR_MID_CODE : `VAOR_BLACK_CODE;
			end
		end
	end

	// ==========================================
	// Coast around vertical sync
	assign preHit = frameLines != '0 && preLines != 8'h00 &&
		lineCnt <= frameLines && (frameLines - lineCnt) <= LINE_W'(preLines);

	// Lines since sync start, last frame length
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			lineCnt <= '0;
			frameLines <= '0;
		end else if (vsRise) begin
			lineCnt <= '0;
			frameLines <= lineCnt;
		end else if (hsRise) begin
			lineCnt <= lineCnt + 1'b1;
		end
	end

	// Next coast state
	always_comb begin
		next_coastState = coastState;
		unique case (coastState)
			VAOR_COAST_OFF: begin
				if (vsRise) begin
					next_coastState = VAOR_COAST_SYNC;
				end else if (preHit) begin
					next_coastState = VAOR_COAST_PRE;
				end
			end
			VAOR_COAST_PRE: begin
				if (vsRise) begin
					next_coastState = VAOR_COAST_SYNC;
				end
			end
			VAOR_COAST_SYNC: begin
				if (vsFall) begin
					next_coastState = (postLines == 8'h00) ? VAOR_COAST_OFF : VAOR_COAST_POST;
				end
			end
			VAOR_COAST_POST: begin
				if (vsRise) begin
					next_coastState = VAOR_COAST_SYNC; // New sync cuts post coast short
				end else if (hsRise && postCnt + 8'h01 >= postLines) begin
					next_coastState = VAOR_COAST_OFF;
				end
			end
		endcase
	end

	// Coast state, post line count and output
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			coastState <= VAOR_COAST_OFF;
			postCnt <= 8'h00;
			pllCoast <= 1'b0;
		end else begin
			coastState <= next_coastState;
			pllCoast <= next_coastState != VAOR_COAST_OFF;
			if (coastState != VAOR_COAST_POST) begin
				postCnt <= 8'h00;
			end else if (hsRise) begin
				postCnt <= postCnt + 8'h01;
			end
		end
	end

	// ==========================================
	// Checks
	lineHold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!wrTo(`VAOR_IDX_TOT_LO) |=> $stable(pllLineTotal))
		else $error("line total moved without low write");
	lineLoad_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		wrTo(`VAOR_IDX_TOT_LO) |=> pllLineTotal == {totalHigh, totalLow})
		else $error("line total not assembled");
	dacManual_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!autoBlackLevelComp ##1 applyNow ##1 1'b1 |=>
		dacCode[2][9:2] == $past(chanOffset[2], 2))
		else $error("manual DAC code wrong");
	dacLowBits_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!autoBlackLevelComp |=> dacCode[0][1:0] == $past(appliedCfg[`VAOR_DACLOW_BASE +: 2]))
		else $error("red DAC low bits wrong");
	digOffset_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		autoBlackLevelComp && chanOffset[1] == `VAOR_MID_CODE |=> digOffset[1] == 8'h00)
		else $error("mid code not zero offset");
	extClampGate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		extClampSel && !clampRise |=> $stable(appliedOffset[0]) && $stable(appliedCfg))
		else $error("DAC update without clamp edge");
	waitBound_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		pending && !extClampSel && waitCnt == WAIT_LAST && !dacWrite |=> !pending)
		else $error("DAC update wait overran");
	coastSync_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		vsRise |=> pllCoast && coastState == VAOR_COAST_SYNC)
		else $error("no coast at vertical sync");
	coastPost_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		coastState == VAOR_COAST_POST |-> postCnt < postLines && pllCoast)
		else $error("post coast overran");
	blcTarget_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		componentIn |=> blcTarget[0] == `VAOR_MID_CODE && blcTarget[1] == `VAOR_BLACK_CODE)
		else $error("component target codes wrong");
	spanFollow_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		applyNow ##1 1'b1 |=> dacSpan == $past(dacCfg[`VAOR_SPAN_BIT], 2))
		else $error("span not applied");
endmodule : vaor_regs

// ### inc/vaor_params.svh
// Named constants of the offset, filter and PLL register bank.
// Assumes inclusion by both the package and the design modules.
`ifndef VAOR_PARAMS_SVH
`define VAOR_PARAMS_SVH
// ==========================================
// Register indices, byte address = 4 * index
`define VAOR_IDX_RED_OFF 6'h09
`define VAOR_IDX_GRN_OFF 6'h0a
`define VAOR_IDX_BLU_OFF 6'h0b
`define VAOR_IDX_DAC_CFG 6'h0c
`define VAOR_IDX_FILTER 6'h0d
`define VAOR_IDX_TOT_HI 6'h0e
`define VAOR_IDX_TOT_LO 6'h0f
`define VAOR_IDX_PHASE 6'h10
`define VAOR_IDX_PRE 6'h11
`define VAOR_IDX_POST 6'h12
`define VAOR_IDX_CTRL 6'h20
`define VAOR_IDX_STAT 6'h21
// ==========================================
// Reset values
`define VAOR_RST_OFF 8'h80
`define VAOR_RST_DAC_CFG 8'h00
`define VAOR_RST_CORNER 3'h7
`define VAOR_RST_PEAK 4'h2
`define VAOR_RST_TOT_HI 6'h03
`define VAOR_RST_TOT_LO 8'h20
`define VAOR_RST_LINE_TOTAL 14'h0320
`define VAOR_RST_PHASE 6'h00
`define VAOR_RST_COAST 8'h04
// ==========================================
// Field positions
`define VAOR_SPAN_BIT 0
`define VAOR_DACLOW_BASE 2
`define VAOR_CORNER_LSB 1
`define VAOR_PEAK_LSB 4
`define VAOR_AUTO_BLACK_LEVEL_COMP_BIT 0
`define VAOR_COMP_BIT 1
`define VAOR_EXTCLAMP_BIT 2
// ==========================================
// Codes and timing
`define VAOR_MID_CODE 8'h80
`define VAOR_BLACK_CODE 8'h00
`define VAOR_DAC_MID 10'h200
`define VAOR_CLAMP_WAIT_MS 100
`define VAOR_CLK_KHZ 50000
`define VAOR_AXI_ADDR_W 8
`define VAOR_RESP_OKAY 2'h0
`define VAOR_RESP_SLVERR 2'h2
`endif

// ### inc/vaor_pkg.sv
// Types and the address decode shared by the bus slave and the bank.
// Assumes the constants header is on the include path.
`include "vaor_params.svh"
package vaor_pkg;
	typedef logic [7:0] vaor_byte_t;
	typedef logic [5:0] vaor_idx_t;
	typedef enum logic [1:0] {
		VAOR_COAST_OFF = 2'b00,
		VAOR_COAST_PRE = 2'b01,
		VAOR_COAST_SYNC = 2'b10,
		VAOR_COAST_POST = 2'b11
	} vaor_coast_t;

	// True for every implemented register index
	function automatic logic vaor_mapped(input vaor_idx_t idx);
		return (idx >= `VAOR_IDX_RED_OFF && idx <= `VAOR_IDX_POST) ||
			idx == `VAOR_IDX_CTRL || idx == `VAOR_IDX_STAT;
	endfunction : vaor_mapped
endpackage : vaor_pkg

// ### rtl/vaor_axil_slave.sv
// AXI4-Lite slave that turns bus transfers into byte register accesses.
// Assumes a master that keeps the AXI4-Lite handshake rules.
`timescale 1ns/100ps
`include "vaor_params.svh"
module vaor_axil_slave (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [`VAOR_AXI_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`VAOR_AXI_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic regWrEn,
	output vaor_pkg::vaor_idx_t regWrIdx,
	output vaor_pkg::vaor_byte_t regWrData,
	output vaor_pkg::vaor_idx_t regRdIdx,
	input wire vaor_pkg::vaor_byte_t regRdData
);
	import vaor_pkg::*;

	logic awHeld;
	logic wHeld;
	logic wLane;
	logic [`VAOR_AXI_ADDR_W-1:0] awAddr;
	vaor_byte_t wByte;
	logic commit;
	logic wrOk;
	logic rdOk;

	// ==========================================
	// Write channels
	assign commit = awHeld && wHeld && !s_axi_bvalid;
	assign wrOk = awAddr[1:0] == 2'h0 && vaor_mapped(awAddr[7:2]);

	// Address capture, freed by the commit
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			awHeld <= 1'b0;
			awAddr <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			awHeld <= 1'b1;
			awAddr <= s_axi_awaddr;
		end else if (commit) begin
			awHeld <= 1'b0;
		end
	end

	// Data capture, low lane only
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wHeld <= 1'b0;
			wByte <= 8'h00;
			wLane <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			wHeld <= 1'b1;
			wByte <= s_axi_wdata[7:0];
			wLane <= s_axi_wstrb[0];
		end else if (commit) begin
			wHeld <= 1'b0;
		end
	end

	// Ready flags, low while an item is held
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= !(awHeld || (s_axi_awvalid && s_axi_awready)) &&
				!(s_axi_bvalid && !s_axi_bready) && !commit;
			s_axi_wready <= !(wHeld || (s_axi_wvalid && s_axi_wready)) &&
				!(s_axi_bvalid && !s_axi_bready) && !commit;
		end
	end

	// Commit strobe and write response
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			regWrEn <= 1'b0;
			regWrIdx <= 6'h00;
			regWrData <= 8'h00;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `VAOR_RESP_OKAY;
		end else begin
			regWrEn <= commit && wrOk && wLane;
			if (commit) begin
				regWrIdx <= awAddr[7:2];
				regWrData <= wByte;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wrOk ? `VAOR_RESP_OKAY : `VAOR_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ==========================================
	// Read channels
	assign regRdIdx = s_axi_araddr[7:2];
	assign rdOk = s_axi_araddr[1:0] == 2'h0 && vaor_mapped(regRdIdx);

	// Read ready, address taken, data one edge later
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `VAOR_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rdOk ? {24'h00_0000, regRdData} : 32'h0000_0000;
			s_axi_rresp <= rdOk ? `VAOR_RESP_OKAY : `VAOR_RESP_SLVERR;
		end else if (s_axi_rvalid) begin
			s_axi_rvalid <= !s_axi_rready;
			s_axi_arready <= s_axi_rready;
		end else begin
			s_axi_arready <= 1'b1;
		end
	end
endmodule : vaor_axil_slave

// ### tb/test_video_afe_offset_pll_regs.sv
// Self-checking bench for the offset, filter and PLL register bank.
// Assumes vaor_regs as top, driven over AXI4-Lite with a 50 MHz clock.
`timescale 1ns/100ps
module test_video_afe_offset_pll_regs;
	logic core_clk = 1'b0, rst_n = 1'b0;
	logic [7:0] awAddr = 8'h00, arAddr = 8'h00;
	logic awValid = 1'b0, wValid = 1'b0, arValid = 1'b0;
	logic [31:0] wData = 32'h0, rData;
	logic awReady, wReady, bValid, arReady, rValid;
	logic [1:0] bResp, rResp;
	logic extClamp = 1'b0, intClamp = 1'b0, hsync = 1'b0, vsync = 1'b0;
	logic auto_black_level_comp, dacSpan, pllCoast;
	logic [2:0][9:0] dacCode;
	logic [2:0][7:0] digOffset, blcTarget;
	logic [2:0] corner;
	logic [3:0] peak;
	logic [13:0] lineTotal;
	logic [5:0] phase;
	logic [31:0] rd;
	int errCount = 0, nTests = 0;
	localparam logic [5:0] IDX [10] = '{6'h09, 6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h0e, 6'h0f, 6'h10,
		6'h11, 6'h12};
	localparam logic [7:0] RST [10] = '{8'h80, 8'h80, 8'h80, 8'h00, 8'h2e, 8'h03, 8'h20, 8'h00,
		8'h04, 8'h04};

	// ==========================================
	// Clock and design
	always #10 core_clk = ~core_clk;
	vaor_regs #(.CLAMP_WAIT_CYC(20)) u_vaor_regs (.core_clk(core_clk), .rst_n(rst_n),
		.s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
		.s_axi_wdata(wData), .s_axi_wstrb(4'h1), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
		.s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(1'b1),
		.s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
		.s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(1'b1),
		.extClampIn(extClamp), .intClampPulse(intClamp), .hsyncIn(hsync), .vsyncIn(vsync),
		.autoBlackLevelComp(auto_black_level_comp), .dacCode(dacCode), .dacSpan(dacSpan),
		.digOffset(digOffset), .blcTarget(blcTarget), .frontEndCorner(corner),
		.peakingSel(peak), .pllLineTotal(lineTotal), .samplePhase(phase), .pllCoast(pllCoast));

	// ==========================================
	// Bus tasks and checks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		nTests++;
		if (got !== exp) begin
			errCount++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Write one byte register, address and data offered together
	task automatic wr(input logic [5:0] i, input logic [7:0] d);
		logic a, w, b;
		a = 1'b1;
		w = 1'b1;
		b = 1'b0;
		awAddr <= {i, 2'b00};
		wData <= {24'h0, d};
		awValid <= 1'b1;
		wValid <= 1'b1;
		while (a || w || !b) begin
			@(posedge core_clk);
			if (bValid) b = 1'b1;
			if (a && awReady) begin
				a = 1'b0;
				awValid <= 1'b0;
			end
			if (w && wReady) begin
				w = 1'b0;
				wValid <= 1'b0;
			end
		end
		chk(bResp, 32'h0);
	endtask : wr

	// Read one word, keeping data and response of the taking edge
	task automatic rdw(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] r);
		logic a, b;
		a = 1'b1;
		b = 1'b0;
		arAddr <= ad;
		arValid <= 1'b1;
		while (a || !b) begin
			@(posedge core_clk);
			if (rValid) begin
				b = 1'b1;
				d = rData;
				r = rResp;
			end
			if (a && arReady) begin
				a = 1'b0;
				arValid <= 1'b0;
			end
		end
	endtask : rdw

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask : cyc

	// One line of sync: hsync pulse with vsync level
	task automatic line(input logic v);
		vsync <= v;
		hsync <= 1'b1;
		@(posedge core_clk);
		hsync <= 1'b0;
		cyc(9);
	endtask : line

	task automatic conclude();
		$display("Checks %0d, mismatches %0d", nTests, errCount);
		if (errCount == 0 && nTests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : conclude

	// ==========================================
	// Watchdog
	initial begin
		cyc(20000);
		errCount++;
		conclude();
	end

	// ==========================================
	// Test sequence
	initial begin
		logic [1:0] rs;
		cyc(6);
		rst_n <= 1'b1;
		cyc(2);
		// Reset values over the bus
		for (int k = 0; k < 10; k++) begin
			rdw({IDX[k], 2'b00}, rd, rs);
			chk(rd, {24'h0, RST[k]});
		end
		chk(dacCode, {3{10'h200}});
		rdw(8'hc0, rd, rs);
		chk(rs, 32'h2);
		chk(rd, 32'h0);
		// Line total loads on the low byte only
		wr(6'h0e, 8'h05);
		cyc(4);
		chk(lineTotal, 14'h0320);
		wr(6'h0f, 8'h55);
		cyc(2);
		chk(lineTotal, 14'h0555);
		// Filter fields, unused bit dropped
		wr(6'h0d, 8'h11);
		cyc(2);
		chk({corner, peak}, {3'h0, 4'h1});
		rdw(8'h34, rd, rs);
		chk(rd, 32'h10);
		wr(6'h10, 8'h3f);
		cyc(2);
		chk(phase, 6'h3f);
		// Manual DAC code applied after the pending wait
		wr(6'h09, 8'h12);
		wr(6'h0c, 8'he5);
		cyc(40);
		chk(dacCode, {10'h203, 10'h202, 10'h049});
		chk(dacSpan, 1'b1);
		// Internal clamp pulse applies at once
		wr(6'h0a, 8'h40);
		intClamp <= 1'b1;
		@(posedge core_clk);
		intClamp <= 1'b0;
		cyc(3);
		chk(dacCode[1], 10'h102);
		// External clamp: no change until its rising edge
		wr(6'h20, 8'h04);
		wr(6'h0b, 8'h20);
		cyc(40);
		chk(dacCode[2], 10'h203);
		rdw(8'h84, rd, rs);
		chk(rd, 32'h1);
		extClamp <= 1'b1;
		cyc(6);
		chk(dacCode[2], 10'h083);
		rdw(8'h84, rd, rs);
		chk(rd, 32'h0);
		extClamp <= 1'b0;
		// Compensation on, component inputs
		wr(6'h20, 8'h03);
		wr(6'h09, 8'h00);
		wr(6'h0a, 8'h80);
		wr(6'h0b, 8'hff);
		cyc(2);
		chk(digOffset, {8'h7f, 8'h00, 8'h80});
		chk(dacCode[0], 10'h200);
		chk(blcTarget, {8'h80, 8'h00, 8'h80});
		chk(auto_black_level_comp, 1'b1);
		// Coast around vertical sync, pre and post of 4 lines
		for (int f = 0; f < 3; f++) begin
			for (int l = 0; l < 20; l++) begin
				line(l < 2);
				if (f == 2 && l == 1) chk(pllCoast, 1'b1);
				if (f == 2 && l == 10) chk(pllCoast, 1'b0);
				if (f == 2 && l == 18) chk(pllCoast, 1'b1);
			end
		end
		conclude();
	end
endmodule : test_video_afe_offset_pll_regs
